// [acra_answer_tx.sv]
`timescale 1ns/1ps
`default_nettype none
module acra_answer_tx
    import acra_pkg::*;
(
    input wire logic ref_clk_in, // System clock
    input wire logic rst_in, // Sync reset, high
    input wire logic load_in, // Start an answer
    input wire acra_pkg::acra_answer_t answer_in, // Answer bytes and count
    input wire logic tx_ready_in, // Host side takes byte
    output logic tx_valid_out, // Byte on offer
    output logic [7:0] tx_data_out, // Byte value
    output logic busy_out // Answer still draining
);
    logic [23:0] shift_reg;
    logic [1:0] left_reg;
    logic [7:0] data_reg;
    logic valid_reg;
    wire logic slot_free;
    wire logic send_next;

    // A new byte moves in once the previous one is gone
    assign slot_free = !valid_reg || tx_ready_in;
    assign send_next = slot_free && (left_reg != 2'h0);
    assign tx_valid_out = valid_reg;
    assign tx_data_out = data_reg;
    assign busy_out = valid_reg || (left_reg != 2'h0);

    // Shift register drains most significant byte first
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            shift_reg <= 24'h000000;
            left_reg <= 2'h0;
            data_reg <= 8'h00;
            valid_reg <= 1'b0;
        end else if (load_in) begin
            shift_reg <= {answer_in.byte0, answer_in.byte1, answer_in.byte2};
            left_reg <= answer_in.count;
        end else if (send_next) begin
            data_reg <= shift_reg[23:16];
            shift_reg <= {shift_reg[15:0], 8'h00};
            left_reg <= left_reg - 2'h1;
            valid_reg <= 1'b1;
        end else if (tx_ready_in) begin
            valid_reg <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// [acra_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module acra_host_model (
    input wire logic clk_in, // Clock
    input wire logic rx_ready_in, // Device took byte
    input wire logic tx_valid_in, // Answer offered
    input wire logic [7:0] tx_data_in, // Answer byte
    output logic rx_valid_out, // Byte offered
    output logic [7:0] rx_data_out, // Byte value
    output logic tx_ready_out // Answer taken
);
    bit slow = 0;
    // Idle line shows inverted data so stale bytes never look valid
    initial begin
        rx_valid_out = 0;
        rx_data_out = 8'hA5;
        tx_ready_out = 0;
    end
    // Whole frame in order, then collect n answer bytes; slow stalls
    task automatic xfer(input logic [7:0] f[$], input int n, output logic [7:0] a[$]);
        int k;
        a = {};
        k = 0;
        // Next byte follows straight after the edge that took the previous one,
        // so a taken byte is never left standing for a second edge
        @(posedge clk_in);
        foreach (f[i]) begin
            #1 rx_valid_out = 1;
            rx_data_out = f[i];
            do @(posedge clk_in); while (!rx_ready_in);
        end
        #1 rx_valid_out = 0;
        rx_data_out = ~rx_data_out;
        while (a.size() < n && k < 200) begin
            @(posedge clk_in);
            k++;
            if (tx_valid_in && tx_ready_out) a.push_back(tx_data_in);
            #1 tx_ready_out = (a.size() < n) && (!slow || !tx_ready_out);
        end
    endtask
endmodule
`default_nettype wire

// [acra_pkg.sv]
package acra_pkg;
    // Command codes and frame constants
    localparam logic [7:0] ACRA_CMD_READ = 8'h08;
    localparam logic [7:0] ACRA_CMD_WRITE = 8'h09;
    localparam logic [7:0] ACRA_READ_LEN = 8'h03;
    localparam logic [7:0] ACRA_WRITE_LEN_PTR = 8'h03;
    localparam logic [7:0] ACRA_WRITE_LEN_VAL = 8'h04;
    localparam logic [7:0] ACRA_READ_ADDR = 8'h69;
    localparam logic [7:0] ACRA_WRITE_ADDR = 8'h68;
    localparam logic [7:0] ACRA_READ_SIZE = 8'h01;
    localparam logic [7:0] ACRA_FLAG_KEEP = 8'h00;
    localparam logic [7:0] ACRA_FLAG_INCR = 8'h01;
    // Register index and field layout
    localparam logic [7:0] ACRA_TUNING_INDEX = 8'h04;
    localparam int ACRA_SENS_MSB = 5;
    localparam int ACRA_SENS_LSB = 4;
    localparam int ACRA_LMI_MSB = 3;
    localparam int ACRA_LMI_LSB = 0;
    localparam logic [7:0] ACRA_TUNING_DEFAULT = 8'h27;
    localparam logic [7:0] ACRA_TUNING_RESET = 8'h00;
    localparam logic [7:0] ACRA_INDEX_RESET = 8'h00;
    localparam logic [7:0] ACRA_RESERVED_MASK = 8'hC0;
    // Answer codes
    localparam logic [7:0] ACRA_RES_OK = 8'h00;
    localparam logic [7:0] ACRA_RES_BAD_LEN = 8'h82;
    localparam logic [7:0] ACRA_LEN_NONE = 8'h00;
    localparam logic [1:0] ACRA_ANS_TWO = 2'h2;
    localparam logic [1:0] ACRA_ANS_THREE = 2'h3;
    localparam int ACRA_PARAM_SLOTS = 4;

    // Answer frame handed to the byte sender
    typedef struct packed {
        logic [1:0] count;
        logic [7:0] byte0;
        logic [7:0] byte1;
        logic [7:0] byte2;
    } acra_answer_t;

    // Parser states, Gray from ACRA_IDLE up to ACRA_RESP; the return to ACRA_IDLE flips two bits
    typedef enum logic [2:0] {
        ACRA_IDLE = 3'h0,
        ACRA_LEN = 3'h1,
        ACRA_PARM = 3'h3,
        ACRA_EXEC = 3'h2,
        ACRA_RESP = 3'h6
    } acra_state_t;
endpackage

// [acra_properties.sv]
`timescale 1ns/1ps
`default_nettype none
module acra_properties
    import acra_pkg::*;
#(
    parameter logic [7:0] TUNING_DEFAULT = ACRA_TUNING_DEFAULT
)(
    input wire logic ref_clk_in, // Clock
    input wire logic rst_in, // Sync reset
    input wire logic rx_valid_in, // Byte offered
    input wire logic [7:0] rx_data_in, // Byte value
    input wire logic rx_ready_out, // Byte taken
    input wire logic tx_valid_out, // Answer offered
    input wire logic [7:0] tx_data_out, // Answer byte
    input wire logic tx_ready_in, // Answer taken
    input wire logic protocol_choose_in, // Default load
    input wire logic [1:0] demod_sensitivity_out, // Bits 5:4
    input wire logic [3:0] load_mod_index_out, // Bits 3:0
    input wire logic [7:0] index_pointer_out // Pointer
);
    // Single domain, reset masks everything
    default clocking dc @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);

    chk_reset_state: assert property ($fell(rst_in) |-> !rx_ready_out && !tx_valid_out
        && index_pointer_out == 8'h00 && {demod_sensitivity_out, load_mod_index_out} == 6'h00)
        else $error("outputs not cleared by reset");
    chk_answer_holds: assert property (tx_valid_out && !tx_ready_in |=>
        tx_valid_out && $stable(tx_data_out)) else $error("answer byte dropped");
    chk_busy_block: assert property (tx_valid_out |-> !rx_ready_out)
        else $error("command taken during answer");
    chk_answer_delay: assert property ($fell(rx_ready_out) |-> ##[1:4] tx_valid_out)
        else $error("answer late");
    chk_ready_return: assert property ($fell(tx_valid_out) |->
        ##[1:3] (rx_ready_out || tx_valid_out)) else $error("command side stuck");
    chk_proto_default: assert property (protocol_choose_in |-> ##2
        {demod_sensitivity_out, load_mod_index_out} == TUNING_DEFAULT[5:0])
        else $error("default tuning not loaded");
    chk_index_cause: assert property (!$stable(index_pointer_out) && !$past(rst_in)
        |-> !$past(rx_ready_out)) else $error("pointer moved without command");
    chk_tuning_cause: assert property ($changed({demod_sensitivity_out, load_mod_index_out})
        && !$past(rst_in, 2) |-> $past(protocol_choose_in, 2) || !$past(rx_ready_out, 2))
        else $error("tuning moved without cause");
endmodule
bind acra_top acra_properties #(.TUNING_DEFAULT(TUNING_DEFAULT)) i_chk (.ref_clk_in,
    .rst_in, .rx_valid_in, .rx_data_in, .rx_ready_out, .tx_valid_out, .tx_data_out,
    .tx_ready_in, .protocol_choose_in, .demod_sensitivity_out, .load_mod_index_out,
    .index_pointer_out);
`default_nettype wire

// [acra_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module acra_tb_top;
    import acra_pkg::*;
    logic ref_clk_in, rst_in, rx_valid_in, rx_ready_out, tx_valid_out;
    logic tx_ready_in, protocol_choose_in;
    logic [7:0] rx_data_in, tx_data_out, index_pointer_out;
    logic [1:0] demod_sensitivity_out;
    logic [3:0] load_mod_index_out;
    logic [7:0] ans[$];
    int err_count = 0;
    int total_checks = 0;

    acra_top i_dut (.ref_clk_in, .rst_in, .rx_valid_in, .rx_data_in, .rx_ready_out,
        .tx_valid_out, .tx_data_out, .tx_ready_in, .protocol_choose_in,
        .demod_sensitivity_out, .load_mod_index_out, .index_pointer_out);
    acra_host_model i_host (.clk_in(ref_clk_in), .rx_ready_in(rx_ready_out),
        .tx_valid_in(tx_valid_out), .tx_data_in(tx_data_out), .rx_valid_out(rx_valid_in),
        .rx_data_out(rx_data_in), .tx_ready_out(tx_ready_in));

    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL %s expected %h seen %h", name, exp, got);
        end
    endtask
    // Send a frame, compare every answer byte
    task automatic run(input logic [7:0] f[$], input logic [7:0] e[$]);
        i_host.xfer(f, e.size(), ans);
        foreach (e[i]) check("answer byte", e[i], ans[i]);
    endtask
    // Fields lag the register, so settle first
    task automatic state(input logic [7:0] idx, input logic [7:0] tun);
        repeat (3) @(posedge ref_clk_in);
        #1;
        check("index", idx, index_pointer_out);
        check("tuning", tun, {2'h0, demod_sensitivity_out, load_mod_index_out});
    endtask
    task automatic pulse;
        @(posedge ref_clk_in);
        #1 protocol_choose_in = 1;
        @(posedge ref_clk_in);
        #1 protocol_choose_in = 0;
    endtask
    task automatic t_defaults;
        state(8'h00, 8'h00);
        pulse();
        run({8'h09, 8'h03, 8'h68, 8'h00, 8'h04}, {8'h00, 8'h00});
        run({8'h08, 8'h03, 8'h69, 8'h01, 8'h00}, {8'h00, 8'h01, 8'h27});
        state(8'h04, 8'h27);
        $display("test defaults done");
    endtask
    task automatic t_writes;
        i_host.slow = 1;
        run({8'h09, 8'h04, 8'h68, 8'h01, 8'h04, 8'h25}, {8'h00, 8'h00});
        state(8'h05, 8'h25);
        run({8'h08, 8'h03, 8'h69, 8'h01, 8'h00}, {8'h00, 8'h01, 8'h00});
        run({8'h09, 8'h04, 8'h68, 8'h00, 8'h04, 8'h1F}, {8'h00, 8'h00});
        state(8'h04, 8'h1F);
        run({8'h08, 8'h03, 8'h69, 8'h01, 8'h00}, {8'h00, 8'h01, 8'h1F});
        i_host.slow = 0;
        $display("test writes done");
    endtask
    task automatic t_errors;
        run({8'h08, 8'h02, 8'h69, 8'h01}, {8'h82, 8'h00});
        run({8'h08, 8'h03, 8'h62, 8'h01, 8'h00}, {8'h82, 8'h00});
        run({8'h09, 8'h05, 8'h68, 8'h00, 8'h06, 8'h33, 8'h11}, {8'h82, 8'h00});
        run({8'h09, 8'h03, 8'h68, 8'h02, 8'h07}, {8'h82, 8'h00});
        state(8'h04, 8'h1F);
        pulse();
        state(8'h04, 8'h27);
        $display("test errors done");
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        ref_clk_in = 0;
        forever #2 ref_clk_in = ~ref_clk_in;
    end
    // Hang guard, far beyond the few hundred cycles needed
    initial begin
        #20000;
        err_count++;
        results();
    end
    initial begin
        rst_in = 1;
        protocol_choose_in = 0;
        repeat (6) @(posedge ref_clk_in);
        #1 rst_in = 0;
        t_defaults();
        t_writes();
        t_errors();
        results();
    end
endmodule
`default_nettype wire

// [acra_top.sv]
`timescale 1ns/1ps
`default_nettype none
module acra_top
    import acra_pkg::*;
#(
    parameter logic [7:0] TUNING_DEFAULT = ACRA_TUNING_DEFAULT
)(
    input wire logic ref_clk_in, // 250 MHz clock
    input wire logic rst_in, // Sync reset, high
    input wire logic rx_valid_in, // Command byte on offer
    input wire logic [7:0] rx_data_in, // Command byte
    output logic rx_ready_out, // Command byte taken
    output logic tx_valid_out, // Answer byte on offer
    output logic [7:0] tx_data_out, // Answer byte
    input wire logic tx_ready_in, // Answer byte taken
    input wire logic protocol_choose_in, // Protocol select executed
    output logic [1:0] demod_sensitivity_out, // Tuning bits 5:4
    output logic [3:0] load_mod_index_out, // Tuning bits 3:0
    output logic [7:0] index_pointer_out // Current index pointer
);
    import acra_pkg::*;

    // Default must leave the reserved bits clear
    if ((TUNING_DEFAULT & ACRA_RESERVED_MASK) != 8'h00) begin : g_bad_default
        $error("TUNING_DEFAULT sets reserved bits");
    end

    acra_state_t state_reg, state_next;
    logic [7:0] code_reg;
    logic [7:0] len_reg;
    logic [7:0] count_reg;
    logic [7:0] param_reg [ACRA_PARAM_SLOTS];
    logic [7:0] tuning_reg;
    logic [7:0] index_reg;
    logic rx_ready_reg;
    logic [1:0] sens_reg;
    logic [3:0] lmi_reg;
    logic answer_load_reg;
    acra_answer_t answer_reg;

    wire logic rx_take;
    wire logic last_param;
    wire logic is_read;
    wire logic is_write;
    wire logic read_ok;
    wire logic write_ptr_ok;
    wire logic write_val_ok;
    wire logic write_ok;
    wire logic store_tuning;
    wire logic [7:0] read_data;
    wire logic [7:0] index_after;
    wire logic tx_busy;
    acra_answer_t answer_next;

    // Byte handshake on the command side
    assign rx_take = rx_valid_in && rx_ready_reg;
    assign last_param = (count_reg == len_reg - 8'h01);

    // Frame classification
    assign is_read = (code_reg == ACRA_CMD_READ);
    assign is_write = (code_reg == ACRA_CMD_WRITE);
    assign read_ok = is_read && (len_reg == ACRA_READ_LEN)
        && (param_reg[0] == ACRA_READ_ADDR) && (param_reg[1] == ACRA_READ_SIZE);
    assign write_ptr_ok = (len_reg == ACRA_WRITE_LEN_PTR);
    assign write_val_ok = (len_reg == ACRA_WRITE_LEN_VAL);
    assign write_ok = is_write && (write_ptr_ok || write_val_ok)
        && (param_reg[0] == ACRA_WRITE_ADDR)
        && ((param_reg[1] == ACRA_FLAG_KEEP) || (param_reg[1] == ACRA_FLAG_INCR));

    // Only the tuning index is backed; other indices read as zero
    assign read_data = (index_reg == ACRA_TUNING_INDEX) ? tuning_reg : 8'h00;
    assign store_tuning = write_ok && write_val_ok
        && (param_reg[2] == ACRA_TUNING_INDEX);
    // Increment applies only to frames that carry a value byte, whether or not the value is stored
    assign index_after = (write_val_ok && (param_reg[1] == ACRA_FLAG_INCR))
        ? 8'(param_reg[2] + 8'h01) : param_reg[2];

    // Answer selection
    always_comb begin
        answer_next = '0;
        if (read_ok) begin
            answer_next.count = ACRA_ANS_THREE;
            answer_next.byte0 = ACRA_RES_OK;
            answer_next.byte1 = ACRA_READ_SIZE;
            answer_next.byte2 = read_data;
        end else if (write_ok) begin
            answer_next.count = ACRA_ANS_TWO;
            answer_next.byte0 = ACRA_RES_OK;
            answer_next.byte1 = ACRA_LEN_NONE;
        end else begin
            answer_next.count = ACRA_ANS_TWO;
            answer_next.byte0 = ACRA_RES_BAD_LEN;
            answer_next.byte1 = ACRA_LEN_NONE;
        end
    end

    // Parser sequencing
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ACRA_IDLE: begin
                if (rx_take) begin
                    state_next = ACRA_LEN;
                end
            end
            ACRA_LEN: begin
                if (rx_take) begin
                    state_next = (rx_data_in == 8'h00) ? ACRA_EXEC : ACRA_PARM;
                end
            end
            ACRA_PARM: begin
                if (rx_take && last_param) begin
                    state_next = ACRA_EXEC;
                end
            end
            ACRA_EXEC: begin
                // Frames for other commands are consumed without an answer
                state_next = (is_read || is_write) ? ACRA_RESP : ACRA_IDLE;
            end
            ACRA_RESP: begin
                if (!answer_load_reg && !tx_busy) begin
                    state_next = ACRA_IDLE;
                end
            end
            default: begin
                state_next = ACRA_IDLE;
            end
        endcase
    end

    // State, frame capture and handshake
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            state_reg <= ACRA_IDLE;
            code_reg <= 8'h00;
            len_reg <= 8'h00;
            count_reg <= 8'h00;
            rx_ready_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            // No new bytes while executing or answering
            rx_ready_reg <= (state_next == ACRA_IDLE) || (state_next == ACRA_LEN)
                || (state_next == ACRA_PARM);
            if (rx_take && state_reg == ACRA_IDLE) begin
                code_reg <= rx_data_in;
            end
            if (rx_take && state_reg == ACRA_LEN) begin
                len_reg <= rx_data_in;
                count_reg <= 8'h00;
            end
            if (rx_take && state_reg == ACRA_PARM) begin
                count_reg <= count_reg + 8'h01;
            end
        end
    end

    // Parameter slots; extra bytes beyond four are dropped
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            param_reg <= '{default: 8'h00};
        end else if (state_reg == ACRA_LEN) begin
            param_reg <= '{default: 8'h00};
        end else if (rx_take && state_reg == ACRA_PARM && count_reg < 8'h04) begin
            param_reg[count_reg[1:0]] <= rx_data_in;
        end
    end

    // Tuning register and index pointer
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            tuning_reg <= ACRA_TUNING_RESET;
            index_reg <= ACRA_INDEX_RESET;
        end else begin
            if (protocol_choose_in) begin
                tuning_reg <= TUNING_DEFAULT;
            end else if (state_reg == ACRA_EXEC && store_tuning) begin
                tuning_reg <= param_reg[3];
            end
            if (state_reg == ACRA_EXEC && write_ok) begin
                index_reg <= index_after;
            end
        end
    end

    // Answer launch and registered field outputs
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            answer_load_reg <= 1'b0;
            answer_reg <= '0;
            sens_reg <= 2'h0;
            lmi_reg <= 4'h0;
        end else begin
            answer_load_reg <= (state_reg == ACRA_EXEC) && (is_read || is_write);
            answer_reg <= answer_next;
            sens_reg <= tuning_reg[ACRA_SENS_MSB:ACRA_SENS_LSB];
            lmi_reg <= tuning_reg[ACRA_LMI_MSB:ACRA_LMI_LSB];
        end
    end

    assign rx_ready_out = rx_ready_reg;
    assign demod_sensitivity_out = sens_reg;
    assign load_mod_index_out = lmi_reg;
    assign index_pointer_out = index_reg;

    acra_answer_tx u_answer_tx (
        .ref_clk_in(ref_clk_in),
        .rst_in(rst_in),
        .load_in(answer_load_reg),
        .answer_in(answer_reg),
        .tx_ready_in(tx_ready_in),
        .tx_valid_out(tx_valid_out),
        .tx_data_out(tx_data_out),
        .busy_out(tx_busy)
    );
endmodule
`default_nettype wire
